// [asr_pkg.sv]
// Package of register offsets, field positions and timing constants for the serial receiver.
package asr_pkg;
   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] OFF_STATUS_CONTROL = 8'h00; // Receive status and control.
   localparam logic [7:0] OFF_BUFFER         = 8'h04; // Receive buffer (low eight data bits).
   localparam logic [7:0] OFF_BAUD           = 8'h08; // Baud divisor, high and low bytes.
   localparam logic [7:0] OFF_INT_STATUS     = 8'h0C; // Sticky event bits, clear on read.
   localparam logic [7:0] OFF_INT_MASK       = 8'h10; // Mask of the same layout.
   // ****************************************
   // Status/control field positions
   // ****************************************
   localparam int BIT_SERIAL_PORT_ENABLE  = 7; // Serial port enable.
   localparam int BIT_NINE  = 6; // Nine-bit receive select.
   localparam int BIT_SINGLE_RECEIVE_ENABLE  = 5; // Single receive enable (no effect in async).
   localparam int BIT_CONTINUOUS_RECEIVE_ENABLE  = 4; // Continuous receive enable.
   localparam int BIT_ADDR  = 3; // Address detect enable.
   localparam int BIT_FRAMING_ERROR_FLAG  = 2; // Framing error flag.
   localparam int BIT_OVERRUN_ERROR_FLAG  = 1; // Overrun error flag.
   localparam int BIT_NINTH = 0; // Received ninth bit.
   // Baud register fields.
   localparam int BIT_HIGH_BAUD = 16; // High baud select.
   localparam int BIT_WIDE_BAUD = 17; // Wide baud generator select.
   // Interrupt status fields.
   localparam int IRQ_RX   = 0; // Character delivered.
   localparam int IRQ_FRAMING_ERROR_FLAG = 1; // Framing error seen.
   localparam int IRQ_OVERRUN_ERROR_FLAG = 2; // Overrun seen.
   localparam int IRQ_W    = 3; // Width of the interrupt registers.
   // ****************************************
   // Reset values, bus answers and bit timing
   // ****************************************
   localparam logic [7:0]  RST_STATUS_CONTROL = 8'h00; // Control reset value.
   localparam logic [17:0] RST_BAUD           = 18'h00000; // Baud reset value.
   localparam logic [1:0]  RESP_OKAY          = 2'h0; // AXI okay answer.
   localparam logic [1:0]  RESP_SLVERR        = 2'h2; // AXI error for unmapped address.
   localparam logic [15:0] SAMPLE_MID         = 16'h0007; // Mid-bit tick count of 16.
   localparam logic [3:0]  TICKS_LAST         = 4'hF; // Last of 16 ticks per bit.
endpackage

// [asr_receiver.sv]
// Asynchronous serial receiver with an AXI4-Lite register slave.
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module asr_receiver (
   // Clock, reset and clock enable.
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        ce,
   // Serial line.
   input  wire logic        rx_line,
   // AXI4-Lite write address.
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   // AXI4-Lite write data.
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   // AXI4-Lite write response.
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address.
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   // AXI4-Lite read data.
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Interrupt and character interrupt.
   output var  logic        irq,
   output var  logic        rx_irq
);
   // ****************************************
   // Declarations
   // ****************************************
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001, // Waiting for a start edge.
      ST_START = 4'b0010, // Checking the start bit at mid point.
      ST_DATA  = 4'b0100, // Shifting data bits.
      ST_STOP  = 4'b1000  // Sampling the stop bit.
   } asr_state_t;
   asr_state_t  state;        // Receiver state.
   logic [7:0]  ctrl;         // Writable control bits (7..3), flags elsewhere.
   logic [17:0] baud;         // Divisor and baud selects.
   logic [15:0] tick_cnt;     // Baud tick prescaler.
   logic        tick;         // One-cycle oversampling tick.
   logic [15:0] tick_div;     // Cycles per oversample tick minus one.
   logic [3:0]  sub_cnt;      // Ticks within a bit.
   logic [3:0]  bit_cnt;      // Data bits taken.
   logic [8:0]  shift;        // Receive shift register.
   logic [7:0]  buffer;       // Receive buffer register.
   logic        buf_full;     // Buffer holds an unread character.
   logic        ninth;        // Received ninth bit.
   logic        framing_error_flag;         // Framing error flag.
   logic        overrun_error_flag;         // Overrun error flag.
   logic [2:0]  int_status;   // Sticky events.
   logic [2:0]  int_mask;     // Event mask.
   logic        char_done;    // Stop bit sampled this cycle.
   logic        deliver;      // Character moves into the buffer.
   logic        accept;       // Character passes address filter.
   logic        port_on;      // Receiver runs.
   logic        line_high;    // Line level seen at the previous tick.
   logic        aw_held;      // Write address captured.
   logic        w_held;       // Write data captured.
   logic [7:0]  aw_addr;      // Captured write address.
   logic [31:0] w_data;       // Captured write data.
   logic [3:0]  w_strb;       // Captured strobes.
   logic        do_write;     // Write performed this cycle.
   logic        do_read;      // Read taken this cycle.
   logic [31:0] next_rdata;   // Read multiplexer.
   logic        next_rerr;    // Unmapped read.
   logic [7:0]  status_word;  // Assembled status/control value.
   logic        nine_sel;     // Nine-bit select.
   logic [3:0]  last_bit;     // Index of last data bit.

   // The port runs only with both enables set.
   assign port_on  = ctrl[asr_pkg::BIT_SERIAL_PORT_ENABLE] & ctrl[asr_pkg::BIT_CONTINUOUS_RECEIVE_ENABLE];
   assign nine_sel = ctrl[asr_pkg::BIT_NINE];
   assign last_bit = nine_sel ? 4'h8 : 4'h7;
   // In nine-bit address mode only characters with the ninth bit high are taken.
   assign accept   = !(nine_sel && ctrl[asr_pkg::BIT_ADDR]) || shift[8];
   assign char_done = tick && (state == ST_STOP) && (sub_cnt == asr_pkg::TICKS_LAST);
   // A character with a low stop bit still enters the buffer with its framing flag.
   assign deliver  = char_done && accept && !buf_full;
   // The divisor is taken as cycles per sixteenth of a bit minus one; selects scale it.
   assign tick_div = baud[asr_pkg::BIT_WIDE_BAUD] ? baud[15:0] :
                     (baud[asr_pkg::BIT_HIGH_BAUD] ? {8'h00, baud[7:0]} :
                                                     {6'h00, baud[7:0], 2'h3});
   assign status_word = {ctrl[7:3], framing_error_flag, overrun_error_flag, ninth};
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign do_read  = s_axi_arvalid && s_axi_arready;

   // ****************************************
   // Baud tick
   // ****************************************
   // Free-running prescaler, held at zero while the port is off.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tick_cnt <= 16'h0000;
         tick     <= 1'b0;
      end else if (ce) begin
         if (!port_on || tick_cnt >= tick_div) begin
            tick_cnt <= 16'h0000;
            tick     <= port_on;
         end else begin
            tick_cnt <= tick_cnt + 16'h0001;
            tick     <= 1'b0;
         end
      end
   end

   // ****************************************
   // Receive state machine
   // ****************************************
   // Samples each bit at its middle tick, LSB first.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state   <= ST_IDLE;
         sub_cnt <= 4'h0;
         bit_cnt <= 4'h0;
         shift   <= 9'h000;
         line_high <= 1'b0;
      end else if (ce) begin
         if (!port_on) begin
            state   <= ST_IDLE;
            sub_cnt <= 4'h0;
            line_high <= 1'b0;
         end else if (tick) begin
            sub_cnt <= sub_cnt + 4'h1;
            // A start is a fall of the line, so a low stop bit or a break is not a start.
            line_high <= rx_line;
            unique case (state)
               ST_IDLE: begin
                  sub_cnt <= 4'h0;
                  if (!rx_line && line_high) begin
                     state <= ST_START;
                  end
               end
               ST_START: begin
                  if (sub_cnt == asr_pkg::SAMPLE_MID[3:0]) begin
                     // A start bit that went high again was a glitch.
                     if (rx_line) begin
                        state <= ST_IDLE;
                     end else begin
                        state   <= ST_DATA;
                        sub_cnt <= 4'h0;
                        bit_cnt <= 4'h0;
                     end
                  end
               end
               ST_DATA: begin
                  if (sub_cnt == asr_pkg::TICKS_LAST) begin
                     shift[bit_cnt] <= rx_line;
                     bit_cnt        <= bit_cnt + 4'h1;
                     if (bit_cnt == last_bit) begin
                        state <= ST_STOP;
                     end
                  end
               end
               ST_STOP: begin
                  if (sub_cnt == asr_pkg::TICKS_LAST) begin
                     state <= ST_IDLE;
                  end
               end
            endcase
         end
      end
   end

   // ****************************************
   // Receive buffer and flags
   // ****************************************
   // Loads the buffer, ninth bit and framing flag; a buffer read frees it.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         buffer   <= 8'h00;
         buf_full <= 1'b0;
         ninth    <= 1'b0;
         framing_error_flag     <= 1'b0;
      end else if (ce) begin
         if (!ctrl[asr_pkg::BIT_SERIAL_PORT_ENABLE]) begin
            buf_full <= 1'b0;
            framing_error_flag     <= 1'b0;
         end else if (deliver) begin
            buffer   <= shift[7:0];
            buf_full <= 1'b1;
            ninth    <= nine_sel ? shift[8] : 1'b0;
            framing_error_flag     <= !rx_line;
         end else if (do_read && s_axi_araddr == asr_pkg::OFF_BUFFER) begin
            buf_full <= 1'b0;
         end
      end
   end

   // Overrun: a finished character finds the buffer full.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         overrun_error_flag <= 1'b0;
      end else if (ce) begin
         if (!ctrl[asr_pkg::BIT_CONTINUOUS_RECEIVE_ENABLE] || !ctrl[asr_pkg::BIT_SERIAL_PORT_ENABLE]) begin
            overrun_error_flag <= 1'b0;
         end else if (char_done && accept && buf_full) begin
            overrun_error_flag <= 1'b1;
         end
      end
   end

   // ****************************************
   // Interrupts
   // ****************************************
   // Sticky events; a read clears them, but a same-cycle event survives.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         int_status <= 3'h0;
      end else if (ce) begin
         int_status <= ((do_read && s_axi_araddr == asr_pkg::OFF_INT_STATUS) ?
                        3'h0 : int_status) |
                       {char_done && accept && buf_full && port_on,
                        deliver && !rx_line, deliver};
      end
   end

   // Level outputs: masked status, and the character-ready interrupt.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq    <= 1'b0;
         rx_irq <= 1'b0;
      end else if (ce) begin
         irq    <= |(int_status & int_mask);
         rx_irq <= buf_full & int_mask[asr_pkg::IRQ_RX];
      end
   end

   // ****************************************
   // Write channel
   // ****************************************
   // Address and data are taken in either order, the answer after both.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h00000000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= asr_pkg::RESP_OKAY;
      end else if (ce) begin
         s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == asr_pkg::OFF_STATUS_CONTROL ||
                             aw_addr == asr_pkg::OFF_BUFFER ||
                             aw_addr == asr_pkg::OFF_BAUD ||
                             aw_addr == asr_pkg::OFF_INT_STATUS ||
                             aw_addr == asr_pkg::OFF_INT_MASK) ?
                            asr_pkg::RESP_OKAY : asr_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register writes; flag bits of the control word are read only.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl     <= asr_pkg::RST_STATUS_CONTROL;
         baud     <= asr_pkg::RST_BAUD;
         int_mask <= 3'h0;
      end else if (ce && do_write) begin
         if (aw_addr == asr_pkg::OFF_STATUS_CONTROL && w_strb[0]) begin
            ctrl <= {w_data[7:3], 3'h0};
         end
         if (aw_addr == asr_pkg::OFF_BAUD) begin
            if (w_strb[0]) begin
               baud[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
               baud[15:8] <= w_data[15:8];
            end
            if (w_strb[2]) begin
               baud[17:16] <= w_data[17:16];
            end
         end
         if (aw_addr == asr_pkg::OFF_INT_MASK && w_strb[0]) begin
            int_mask <= w_data[2:0];
         end
      end
   end

   // ****************************************
   // Read channel
   // ****************************************
   // Read multiplexer; unmapped addresses answer with an error and zero.
   always_comb begin
      next_rdata = 32'h00000000;
      next_rerr  = 1'b0;
      unique case (s_axi_araddr)
         asr_pkg::OFF_STATUS_CONTROL: next_rdata = {24'h000000, status_word};
         asr_pkg::OFF_BUFFER:         next_rdata = {24'h000000, buffer};
         asr_pkg::OFF_BAUD:           next_rdata = {14'h0000, baud};
         asr_pkg::OFF_INT_STATUS:     next_rdata = {29'h00000000, int_status};
         asr_pkg::OFF_INT_MASK:       next_rdata = {29'h00000000, int_mask};
         default:                     next_rerr  = 1'b1;
      endcase
   end

   // One read at a time; address ready is offered only while idle.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= asr_pkg::RESP_OKAY;
      end else if (ce) begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (do_read) begin
            s_axi_rvalid  <= 1'b1;
            s_axi_arready <= 1'b0;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rerr ? asr_pkg::RESP_SLVERR : asr_pkg::RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // asr_receiver
`default_nettype wire

// [asr_receiver_asserts.sv]
// Checker of the receiver's register-bus answers and receive interrupt.
`timescale 1ns/1ps
`default_nettype none
module asr_chk (
   // Clock and reset.
   input wire logic        clk,
   input wire logic        rstn,
   // Write channels.
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   // Read channels.
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Interrupts.
   input wire logic        irq,
   input wire logic        rx_irq
);
   // ******************************************
   // Helper logic and properties
   // ******************************************
   logic [7:0] rd_addr;  // Address of the read under way.
   logic       ar_hit;   // Read address taken.
   logic       aw_both;  // Write address and data taken together.
   logic       port_off; // Control write that clears the port enable.
   assign ar_hit = s_axi_arvalid && s_axi_arready;
   assign aw_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign port_off = aw_both && s_axi_awaddr == asr_pkg::OFF_STATUS_CONTROL
                     && s_axi_wstrb[0] && !s_axi_wdata[asr_pkg::BIT_SERIAL_PORT_ENABLE];
   // Keeps the read address so that its answer can be judged.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_addr <= 8'h00;
      end else if (ar_hit) begin
         rd_addr <= s_axi_araddr;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   read_answer_a: assert property (ar_hit |=> s_axi_rvalid)
      else $error("read answer late");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer moved");
   write_answer_a: assert property (aw_both |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer moved");
   busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   unmapped_read_a: assert property (s_axi_rvalid && rd_addr > asr_pkg::OFF_INT_MASK |->
      s_axi_rresp == asr_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
   buffer_free_a: assert property (ar_hit && s_axi_araddr == asr_pkg::OFF_BUFFER |-> ##[1:4] !rx_irq)
      else $error("buffer read left receive interrupt up");
   port_off_a: assert property (port_off |-> ##[1:4] !rx_irq)
      else $error("port disable left receive interrupt up");
   cover property ($rose(rx_irq));
   cover property ($rose(irq));
   cover property (s_axi_rvalid && s_axi_rresp == asr_pkg::RESP_SLVERR);
endmodule // asr_chk
bind asr_receiver asr_chk chk_u (.clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .irq(irq), .rx_irq(rx_irq));
`default_nettype wire

// [asr_tx_model.sv]
// Remote serial transmitter that drives the receive line.
`timescale 1ns/1ps
`default_nettype none
module asr_tx_model #(
   parameter int BIT_CYC = 16 // Clock cycles per bit.
) (
   // Clock.
   input  wire logic clk,
   // Line towards the receiver.
   output var  logic rx_line
);
   // ******************************************
   // Character framing
   // ******************************************
   // The line rests high between characters.
   initial rx_line = 1'b1;
   // Sends start, nb data bits and a stop bit, then rests two bit times.
   task automatic send(input logic [8:0] d, input int nb, input logic stop);
      for (int i = 0; i < nb + 2; i++) begin
         @(posedge clk);
         rx_line <= (i == 0) ? 1'b0 : (i == nb + 1) ? stop : d[i - 1];
         repeat (BIT_CYC - 1) @(posedge clk);
      end
      @(posedge clk);
      rx_line <= 1'b1;
      repeat (2 * BIT_CYC) @(posedge clk);
   endtask
endmodule // asr_tx_model
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the asynchronous serial receiver.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // ******************************************
   // Signals, design and partner
   // ******************************************
   localparam logic [7:0] CTL = asr_pkg::OFF_STATUS_CONTROL; // Control word.
   localparam logic [7:0] BUF = asr_pkg::OFF_BUFFER;         // Buffer word.
   localparam logic [7:0] IST = asr_pkg::OFF_INT_STATUS;     // Event word.
   logic        clk, rx_line, awready, wready, bvalid, arready, rvalid, irq, rx_irq;
   logic        rstn = 1'b0, ce = 1'b1, awvalid = 1'b0, wvalid = 1'b0; // Bench inputs.
   logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;          // Bench inputs.
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;                        // Addresses.
   logic [31:0] wdata = 32'h0, rdata, rv;                              // Data words.
   logic [3:0]  wstrb = 4'hF;                                          // Strobes.
   logic [1:0]  bresp, rresp, rsp;                                     // Answers.
   int          num_errors = 0, num_checks = 0, cyc = 0;               // Counters.
   // Free-running clock of 10 ns.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   asr_receiver dut_u (.clk(clk), .rstn(rstn), .ce(ce), .rx_line(rx_line),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .irq(irq), .rx_irq(rx_irq));
   // The model drives the receive pin directly as a digital input.
   asr_tx_model #(.BIT_CYC(16)) tx_u (.clk(clk), .rx_line(rx_line));
   // Compares one value and counts the outcome.
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   // Writes one word, releasing each channel when it is taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit ad = 0, wd = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         ad = ad | awready;
         wd = wd | wready;
         if (ad) awvalid <= 1'b0;
         if (wd) wvalid <= 1'b0;
      end while (!(ad && wd));
      do @(posedge clk); while (bvalid !== 1'b1);
      rsp = bresp;
      bready <= 1'b0;
   endtask
   // Reads one word into rv and its answer into rsp.
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      rv = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask
   // Reads one word and compares it.
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk($sformatf("reg %h", a), e, rv);
   endtask
   // Checks both interrupt outputs after they have settled.
   task automatic ints(input logic i, input logic r);
      repeat (2) @(posedge clk);
      chk("irq", {31'h0, i}, {31'h0, irq});
      chk("rx_irq", {31'h0, r}, {31'h0, rx_irq});
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Cuts a hang short.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         num_errors++;
         summarize();
      end
   end
   // ******************************************
   // Test sequence
   // ******************************************
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      rc(CTL, 32'h0);
      rc(asr_pkg::OFF_BAUD, 32'h0);
      wr(asr_pkg::OFF_BAUD, 32'h0002_0000);
      wr(asr_pkg::OFF_INT_MASK, 32'h7);
      wr(CTL, 32'h90);
      tx_u.send(9'h0A5, 8, 1'b1);
      ints(1'b1, 1'b1);
      rc(CTL, 32'h90);
      rc(BUF, 32'hA5);
      rc(IST, 32'h1);
      ints(1'b0, 1'b0);
      wr(CTL, 32'hD0);
      tx_u.send(9'h13C, 9, 1'b1);
      rc(CTL, 32'hD1);
      rc(BUF, 32'h3C);
      rc(IST, 32'h1);
      wr(CTL, 32'hD8);
      tx_u.send(9'h055, 9, 1'b1);
      ints(1'b0, 1'b0);
      tx_u.send(9'h17E, 9, 1'b1);
      rc(CTL, 32'hD9);
      rc(BUF, 32'h7E);
      wr(CTL, 32'hD0);
      tx_u.send(9'h011, 9, 1'b1);
      rc(CTL, 32'hD0);
      rc(BUF, 32'h11);
      wr(CTL, 32'h90);
      tx_u.send(9'h033, 8, 1'b0);
      rc(CTL, 32'h94);
      rc(BUF, 32'h33);
      tx_u.send(9'h044, 8, 1'b1);
      rc(CTL, 32'h90);
      rc(BUF, 32'h44);
      rc(IST, 32'h3);
      tx_u.send(9'h061, 8, 1'b1);
      tx_u.send(9'h062, 8, 1'b1);
      rc(CTL, 32'h92);
      rc(BUF, 32'h61);
      rc(IST, 32'h5);
      rc(CTL, 32'h92);
      wr(CTL, 32'h80);
      rc(CTL, 32'h80);
      tx_u.send(9'h077, 8, 1'b1);
      ints(1'b0, 1'b0);
      rc(IST, 32'h0);
      wr(CTL, 32'h90);
      tx_u.send(9'h012, 8, 1'b1);
      ints(1'b1, 1'b1);
      wr(CTL, 32'h00);
      ints(1'b1, 1'b0);
      rc(CTL, 32'h0);
      rc(IST, 32'h1);
      wr(asr_pkg::OFF_INT_MASK, 32'h0);
      wr(CTL, 32'h90);
      tx_u.send(9'h021, 8, 1'b1);
      ints(1'b0, 1'b0);
      wr(asr_pkg::OFF_INT_MASK, 32'h1);
      ints(1'b1, 1'b1);
      rc(asr_pkg::OFF_INT_MASK, 32'h1);
      rc(IST, 32'h1);
      rc(BUF, 32'h21);
      ints(1'b0, 1'b0);
      rd(8'h14);
      chk("unmapped rdata", 32'h0, rv);
      chk("unmapped rresp", {30'h0, asr_pkg::RESP_SLVERR}, {30'h0, rsp});
      wr(8'h14, 32'hFF);
      chk("unmapped bresp", {30'h0, asr_pkg::RESP_SLVERR}, {30'h0, rsp});
      summarize();
   end
endmodule // testbench
`default_nettype wire
